// ===== hdl/ebad_consts.vh
/*
 * shared constants of the 8-bit arithmetic datapath: instruction fields,
 * operation codes, mapped control register addresses, status bit positions,
 * memory sizes and reset values.
 * assumes it is included by its bare name from the design files.
 */
`ifndef EBAD_CONSTS_VH
`define EBAD_CONSTS_VH

// ====================================================================
// memory geometry
`define EBAD_DATA_W 8
`define EBAD_INSTR_W 12
`define EBAD_IP_W 10
`define EBAD_ADDR_W 7
`define EBAD_PROG_WORDS_SMALL 512
`define EBAD_PROG_WORDS_LARGE 1024
`define EBAD_DATA_BYTES_SMALL 25
`define EBAD_DATA_BYTES_MID 41
`define EBAD_DATA_BYTES_LARGE 72
`define EBAD_MEM_DEPTH 72
`define EBAD_MEM_IDX_W 7

// ====================================================================
// instruction word fields
`define EBAD_OP_HI 11
`define EBAD_OP_LO 8
`define EBAD_DST_BIT 7
`define EBAD_ADR_HI 6
`define EBAD_LIT_HI 7

// ====================================================================
// operation codes
`define EBAD_OP_ADDF 4'h0
`define EBAD_OP_SUBF 4'h1
`define EBAD_OP_ANDF 4'h2
`define EBAD_OP_IORF 4'h3
`define EBAD_OP_XORF 4'h4
`define EBAD_OP_COM 4'h5
`define EBAD_OP_INC 4'h6
`define EBAD_OP_DEC 4'h7
`define EBAD_OP_RLC 4'h8
`define EBAD_OP_RRC 4'h9
`define EBAD_OP_SWAP 4'ha
`define EBAD_OP_CLR 4'hb
`define EBAD_OP_MOV 4'hc
`define EBAD_OP_ANDL 4'hd
`define EBAD_OP_IORL 4'he
`define EBAD_OP_MOVL 4'hf

// ====================================================================
// mapped control registers and storage window
`define EBAD_ADR_INDIRECT 7'h00
`define EBAD_ADR_IPTR 7'h01
`define EBAD_ADR_STATUS 7'h02
`define EBAD_ADR_SELECT 7'h03
`define EBAD_ADR_MEM_BASE 7'h04
`define EBAD_ADR_MEM_LAST 7'h4b

// ====================================================================
// status bit positions and reset values
`define EBAD_ST_CARRY 0
`define EBAD_ST_HALF 1
`define EBAD_ST_ZERO 2
`define EBAD_RST_STATUS 8'h00
`define EBAD_RST_W 8'h00
`define EBAD_RST_SELECT 8'h00
`define EBAD_RST_IP 10'h000

`endif

// ===== hdl/ebad_core.v
/*
 * 8-bit arithmetic datapath: working accumulator, status flags, mapped
 * control registers, indirect addressing and a two-stage pipeline.
 * assumes the sequencer returns the 12-bit word at o_fetch_addr in the same
 * cycle, flagged by i_instr_valid; the word offered while a pointer write
 * executes is dropped by the core itself, the cycle before o_flush pulses.
 */
// Operation
// - 8-bit add, subtract, shift and logic operations
// - arithmetic uses two's complement on bytes
// - two operands: accumulator plus register or literal
// - single operand: accumulator or data register
// - accumulator is internal, never at any address
// - flags updated per operation, else kept
// - subtraction carry and half carry mean no borrow, low on a borrow
// - control registers mapped, direct and indirect reachable
// - every operation but the three literal ones works on every register
// - 12-bit program words, 8-bit data bytes
// - 12-bit words, fetch overlaps execute
`timescale 1ns/1ps
`include "ebad_consts.vh"

module ebad_core (
	// clock and reset
	input wire i_mclk,
	input wire i_srst,
	// instruction stream from the sequencer
	input wire [`EBAD_INSTR_W-1:0] i_instr,
	input wire i_instr_valid,
	// fetch side
	output wire [`EBAD_IP_W-1:0] o_fetch_addr,
	output wire o_flush,
	// observed state
	output wire [`EBAD_DATA_W-1:0] o_w_value,
	output wire [`EBAD_DATA_W-1:0] o_status,
	output wire [`EBAD_DATA_W-1:0] o_result,
	output wire o_exec_done
);

	// ================================================================
	// arithmetic helper
	// returns {carry, half carry, sum}; used for add, subtract, inc, dec
	function [9:0] ebad_add;
		input [7:0] x;
		input [7:0] y;
		input cin;
		reg [4:0] lo;
		reg [4:0] hi;
		begin
			lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
			hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
			ebad_add = {hi[4], lo[4], hi[3:0], lo[3:0]};
		end
	endfunction

	// ================================================================
	// architectural state
	reg [`EBAD_DATA_W-1:0] w_reg; // accumulator, no address of its own
	reg [`EBAD_DATA_W-1:0] status_reg; // flags plus spare bits
	reg [`EBAD_DATA_W-1:0] select_reg; // indirect pointer
	reg [`EBAD_IP_W-1:0] ip_reg; // next word to fetch
	// pipeline execute stage
	reg [`EBAD_INSTR_W-1:0] ex_instr_reg; // word in execute
	reg ex_valid_reg; // execute stage holds a word
	reg [`EBAD_ADDR_W-1:0] ex_addr_reg; // resolved operand address
	reg [`EBAD_IP_W-1:0] ex_ip_reg; // address of the executing word
	// registered outputs
	reg [`EBAD_DATA_W-1:0] result_reg; // last result
	reg exec_done_reg; // pulse per executed word
	reg flush_reg; // pulse on pointer write

	// ================================================================
	// memory interface
	wire [`EBAD_DATA_W-1:0] mem_rdata; // registered byte from storage
	reg mem_we; // storage write strobe
	reg [`EBAD_MEM_IDX_W-1:0] mem_widx; // storage write index
	reg [`EBAD_MEM_IDX_W-1:0] mem_ridx; // storage read index
	reg [`EBAD_ADDR_W-1:0] fetch_addr_eff; // operand address of incoming word

	// ================================================================
	// execute stage combinational results
	reg [`EBAD_DATA_W-1:0] fv; // file operand value
	reg [`EBAD_DATA_W-1:0] opnd; // single operand value
	reg [`EBAD_DATA_W-1:0] res; // alu result
	reg [9:0] sum; // adder output
	reg new_c; // carry value
	reg new_h; // half carry value
	reg upd_c; // carry affected
	reg upd_h; // half carry affected
	reg upd_z; // zero affected
	reg to_w; // result goes to accumulator
	reg to_f; // result goes to data register
	reg [`EBAD_DATA_W-1:0] w_next; // accumulator next value
	reg [`EBAD_DATA_W-1:0] status_next; // status next value
	reg [`EBAD_DATA_W-1:0] select_next; // pointer next value
	reg ip_write; // executed word redirects the fetch
	wire [3:0] ex_op; // operation code in execute
	wire ex_dst_f; // destination select in execute
	wire [`EBAD_DATA_W-1:0] ex_lit; // literal in execute
	wire [`EBAD_IP_W-1:0] ip_plus; // pointer of the following word

	assign ex_op = ex_instr_reg[`EBAD_OP_HI:`EBAD_OP_LO];
	assign ex_dst_f = ex_instr_reg[`EBAD_DST_BIT];
	assign ex_lit = ex_instr_reg[`EBAD_LIT_HI:0];
	assign ip_plus = ex_ip_reg + 10'h001;

	// ================================================================
	// operand read: mapped registers or storage bytes
	always @* begin
		fv = 8'h00;
		case (ex_addr_reg)
			`EBAD_ADR_INDIRECT: fv = 8'h00; // pointer aimed at itself reads zero
			`EBAD_ADR_IPTR: fv = ip_plus[7:0];
			`EBAD_ADR_STATUS: fv = status_reg;
			`EBAD_ADR_SELECT: fv = select_reg;
			default: begin
				// bytes past the storage window read as zero
				if (ex_addr_reg <= `EBAD_ADR_MEM_LAST) begin
					fv = mem_rdata;
				end
			end
		endcase
	end

	// ================================================================
	// alu: one case over every operation, no register is special
	always @* begin
		res = 8'h00;
		sum = 10'h000;
		new_c = 1'b0;
		new_h = 1'b0;
		upd_c = 1'b0;
		upd_h = 1'b0;
		upd_z = 1'b0;
		to_w = 1'b0;
		to_f = 1'b0;
		// single operand words work in place on w or the register
		opnd = ex_dst_f ? fv : w_reg;
		if (ex_valid_reg) begin
			// literal words always land in w, the rest follow the destination bit
			to_f = ex_dst_f && (ex_op < `EBAD_OP_ANDL);
			to_w = ~to_f;
			case (ex_op)
				`EBAD_OP_ADDF, `EBAD_OP_SUBF: begin
					// register minus w as register plus not w plus one;
					// carry low means a borrow happened
					if (ex_op == `EBAD_OP_ADDF) begin
						sum = ebad_add(fv, w_reg, 1'b0);
					end else begin
						sum = ebad_add(fv, ~w_reg, 1'b1);
					end
					res = sum[7:0];
					new_c = sum[9];
					new_h = sum[8];
					upd_c = 1'b1;
					upd_h = 1'b1;
					upd_z = 1'b1;
				end
				`EBAD_OP_ANDF, `EBAD_OP_IORF, `EBAD_OP_XORF: begin
					res = (ex_op == `EBAD_OP_ANDF) ? (fv & w_reg) :
						((ex_op == `EBAD_OP_IORF) ? (fv | w_reg) : (fv ^ w_reg));
					upd_z = 1'b1;
				end
				`EBAD_OP_COM: begin
					res = ~opnd;
					upd_z = 1'b1;
				end
				`EBAD_OP_INC, `EBAD_OP_DEC: begin
					// counting moves only the zero flag
					sum = ebad_add(opnd, (ex_op == `EBAD_OP_INC) ? 8'h00 : 8'hff, ex_op == `EBAD_OP_INC);
					res = sum[7:0];
					upd_z = 1'b1;
				end
				`EBAD_OP_RLC: begin
					// rotate left through carry
					res = {opnd[6:0], status_reg[`EBAD_ST_CARRY]};
					new_c = opnd[7];
					upd_c = 1'b1;
				end
				`EBAD_OP_RRC: begin
					// rotate right through carry
					res = {status_reg[`EBAD_ST_CARRY], opnd[7:1]};
					new_c = opnd[0];
					upd_c = 1'b1;
				end
				`EBAD_OP_SWAP: begin
					res = {opnd[3:0], opnd[7:4]};
				end
				`EBAD_OP_CLR: begin
					res = 8'h00;
					upd_z = 1'b1;
				end
				`EBAD_OP_MOV: begin
					// to register: store w, flags kept; to w: load, zero moves
					if (ex_dst_f) begin
						res = w_reg;
					end else begin
						res = fv;
						upd_z = 1'b1;
					end
				end
				`EBAD_OP_ANDL: begin
					res = w_reg & ex_lit;
					upd_z = 1'b1;
				end
				`EBAD_OP_IORL: begin
					res = w_reg | ex_lit;
					upd_z = 1'b1;
				end
				`EBAD_OP_MOVL: begin
					res = ex_lit;
				end
				default: begin
					res = 8'h00;
				end
			endcase
		end
	end

	// ================================================================
	// write back decode and next state
	always @* begin
		w_next = to_w ? res : w_reg;
		select_next = select_reg;
		status_next = status_reg;
		ip_write = 1'b0;
		mem_we = 1'b0;
		mem_widx = 7'h00;
		if (to_f) begin
			case (ex_addr_reg)
				`EBAD_ADR_INDIRECT: begin
					// writing through a pointer aimed at itself is dropped
				end
				`EBAD_ADR_IPTR: ip_write = 1'b1;
				`EBAD_ADR_STATUS: status_next = res;
				`EBAD_ADR_SELECT: select_next = res;
				default: begin
					if (ex_addr_reg <= `EBAD_ADR_MEM_LAST) begin
						mem_we = 1'b1;
						mem_widx = ex_addr_reg - `EBAD_ADR_MEM_BASE;
					end
				end
			endcase
		end
		// flag updates win over a plain write to the status byte
		status_next[`EBAD_ST_CARRY] = upd_c ? new_c : status_next[`EBAD_ST_CARRY];
		status_next[`EBAD_ST_HALF] = upd_h ? new_h : status_next[`EBAD_ST_HALF];
		status_next[`EBAD_ST_ZERO] = upd_z ? (res == 8'h00) : status_next[`EBAD_ST_ZERO];
	end

	// ================================================================
	// operand address of the incoming word, resolved against the pointer
	// that the executing word is about to leave behind
	always @* begin
		fetch_addr_eff = i_instr[`EBAD_ADR_HI:0];
		if (i_instr[`EBAD_ADR_HI:0] == `EBAD_ADR_INDIRECT) begin
			fetch_addr_eff = select_next[`EBAD_ADDR_W-1:0];
		end
		mem_ridx = 7'h00;
		if ((fetch_addr_eff >= `EBAD_ADR_MEM_BASE) && (fetch_addr_eff <= `EBAD_ADR_MEM_LAST)) begin
			mem_ridx = fetch_addr_eff - `EBAD_ADR_MEM_BASE;
		end
	end

	// ================================================================
	// state registers; the word fetched while a pointer write executes
	// is from the old path and is discarded, so a jump costs two cycles
	always @(posedge i_mclk) begin
		if (i_srst) begin
			w_reg <= `EBAD_RST_W;
			status_reg <= `EBAD_RST_STATUS;
			select_reg <= `EBAD_RST_SELECT;
			ip_reg <= `EBAD_RST_IP;
			ex_instr_reg <= 12'h000;
			ex_valid_reg <= 1'b0;
			ex_addr_reg <= 7'h00;
			ex_ip_reg <= `EBAD_RST_IP;
			result_reg <= 8'h00;
			exec_done_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			w_reg <= w_next;
			status_reg <= status_next;
			select_reg <= select_next;
			exec_done_reg <= ex_valid_reg;
			flush_reg <= ip_write;
			if (ex_valid_reg) begin
				result_reg <= res;
			end
			if (ip_write) begin
				// pointer low byte loaded, page bits kept
				ip_reg <= {ex_ip_reg[9:8], res};
				ex_valid_reg <= 1'b0;
			end else if (i_instr_valid) begin
				// fetch of next word overlaps this execute
				ex_instr_reg <= i_instr;
				ex_addr_reg <= fetch_addr_eff;
				ex_ip_reg <= ip_reg;
				ex_valid_reg <= 1'b1;
				ip_reg <= ip_reg + 10'h001;
			end else begin
				ex_valid_reg <= 1'b0;
			end
		end
	end

	// ================================================================
	// data byte storage
	ebad_regfile u_regfile (
		.i_mclk(i_mclk),
		.i_we(mem_we),
		.i_waddr(mem_widx),
		.i_wdata(res),
		.i_raddr(mem_ridx),
		.o_rdata(mem_rdata)
	);

	// ================================================================
	// outputs, each straight from a flip-flop
	assign o_fetch_addr = ip_reg;
	assign o_flush = flush_reg;
	assign o_w_value = w_reg;
	assign o_status = status_reg;
	assign o_result = result_reg;
	assign o_exec_done = exec_done_reg;

endmodule // ebad_core

// ===== hdl/ebad_regfile.v
/*
 * general purpose data byte storage of the datapath.
 * assumes one write and one read per cycle; read data is registered and
 * a write to the address being read is passed straight through.
 */
`timescale 1ns/1ps
`include "ebad_consts.vh"

module ebad_regfile (
	// clock
	input wire i_mclk,
	// write port
	input wire i_we,
	input wire [`EBAD_MEM_IDX_W-1:0] i_waddr,
	input wire [`EBAD_DATA_W-1:0] i_wdata,
	// read port
	input wire [`EBAD_MEM_IDX_W-1:0] i_raddr,
	output wire [`EBAD_DATA_W-1:0] o_rdata
);

	// ================================================================
	// storage
	reg [`EBAD_DATA_W-1:0] mem [0:`EBAD_MEM_DEPTH-1]; // data bytes
	reg [`EBAD_DATA_W-1:0] rdata_reg; // registered read data

	// write first: the pipeline reads in the same cycle it writes back,
	// so the new byte must win or the next instruction sees stale data
	always @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_we && (i_waddr == i_raddr)) begin
			rdata_reg <= i_wdata;
		end else begin
			rdata_reg <= mem[i_raddr];
		end
	end

	assign o_rdata = rdata_reg;

endmodule // ebad_regfile

// ===== tb/ebad_core_chk.sv
/* port checker of the 8-bit datapath, bound into ebad_core.
   assumes the single core clock and the synchronous active-high reset. */
`timescale 1ns/1ps
// ================================
// checker
module ebad_core_chk (
	// clock and reset
	input wire i_mclk,
	input wire i_srst,
	// instruction stream
	input wire [11:0] i_instr,
	input wire i_instr_valid,
	// observed outputs
	input wire [9:0] o_fetch_addr,
	input wire o_flush,
	input wire [7:0] o_w_value,
	input wire [7:0] o_status,
	input wire [7:0] o_result,
	input wire o_exec_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	reg [11:0] ir1_reg; // word one edge old
	reg [11:0] ir2_reg; // word whose done pulse shows now
	// delay the word so it lines up with its done pulse
	always @(posedge i_mclk) begin
		ir1_reg <= i_instr;
		ir2_reg <= ir1_reg;
	end
	wire [3:0] op = ir2_reg[11:8]; // finished operation
	wire dst = ir2_reg[7]; // high: register destination
	// operations that own the zero flag
	wire zop = (op <= 4'h7) || (op == 4'hb) || (op == 4'hd) || (op == 4'he) || (op == 4'hc && !dst);
	// flag-neutral operations, status as target left out on purpose
	wire kop = (op == 4'ha || op == 4'hf || (op == 4'hc && dst)) && ir2_reg[6:0] != 7'h02;
	sequence s_done_next;
		##1 o_exec_done;
	endsequence
	property p_take;
		i_instr_valid |=> (o_flush or s_done_next);
	endproperty
	a_take: assert property (p_take) else $error("word neither ran nor was flushed");
	property p_done_cause;
		o_exec_done |-> $past(i_instr_valid, 2);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without a word");
	property p_fetch;
		i_instr_valid |=> o_fetch_addr == $past(o_fetch_addr) + 10'h001 || o_flush;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch pointer did not step");
	property p_jump;
		o_flush |-> o_exec_done && o_fetch_addr[7:0] == o_result ##1 !o_flush;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");
	property p_zero;
		o_exec_done && zop |-> o_status[2] == (o_result == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_keep;
		o_exec_done && kop |-> o_status[2:0] == $past(o_status[2:0]);
	endproperty
	a_keep: assert property (p_keep) else $error("flags moved");
	property p_add;
		o_exec_done && op == 4'h0 |-> o_status[0] == (o_result < $past(o_w_value))
			&& o_status[1] == (o_result[3:0] < $past(o_w_value[3:0]));
	endproperty
	a_add: assert property (p_add) else $error("add carry wrong");
	property p_sub;
		o_exec_done && op == 4'h1 |-> o_status[0] == (({1'b0, o_result} + {1'b0, $past(o_w_value)}) < 9'h100)
			&& o_status[1] == (({1'b0, o_result[3:0]} + {1'b0, $past(o_w_value[3:0])}) < 5'h10);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract borrow wrong");
	property p_wkeep;
		o_exec_done && dst && op <= 4'hc |-> o_w_value == $past(o_w_value);
	endproperty
	a_wkeep: assert property (p_wkeep) else $error("accumulator hit");
	property p_reset;
		disable iff (1'b0) i_srst |=> o_w_value == 8'h00 && o_status == 8'h00 && o_fetch_addr == 10'h000;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // ebad_core_chk

bind ebad_core ebad_core_chk chk (.i_mclk, .i_srst, .i_instr, .i_instr_valid, .o_fetch_addr,
	.o_flush, .o_w_value, .o_status, .o_result, .o_exec_done);

// ===== tb/ebad_core_tb.sv
/* self-checking bench of the 8-bit datapath.
   assumes ebad_core, the sequencer model and the bound checker. */
`timescale 1ns/1ps
// ================================
// bench top
module ebad_core_tb;
	reg i_mclk = 1'b0; // 40 MHz core clock
	reg i_srst = 1'b1; // held three cycles
	reg run = 1'b0; // offer words
	wire [11:0] instr;
	wire valid;
	wire [9:0] fetch;
	wire flush;
	wire done;
	wire [7:0] w;
	wire [7:0] st;
	wire [7:0] res; // last executed result
	integer miscompares = 0;
	integer checks_done = 0;
	integer i;
	// tables: op f w result flags / word result / word preset w flags
	localparam [255:0] ARI = {32'h0010f102, 32'h001ff007, 32'h08080005, 32'h03412460,
		32'h110010f1, 32'h10102ff0, 32'h10505007, 32'h13812263};
	localparam [179:0] REG = {20'h2a00c, 20'h3a03f, 20'h4a033, 20'h5a0c3, 20'h6a03d,
		20'h7a03b, 20'haa0c3, 20'h0a04b, 20'h1a02d};
	localparam [279:0] WOP = {28'h5007693, 28'h6000970, 28'h7000950, 28'h80012d1, 28'h9001cb0,
		28'ha007697, 28'hb000004, 28'hd0f0060, 28'he010970, 28'hd000004};
	always #12.5 i_mclk = ~i_mclk;
	ebad_core uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_instr(instr), .i_instr_valid(valid),
		.o_fetch_addr(fetch), .o_flush(flush), .o_w_value(w), .o_status(st), .o_result(res),
		.o_exec_done(done));
	ebad_seq_model seq (.i_mclk(i_mclk), .i_srst(i_srst), .i_run(run), .i_fetch_addr(fetch),
		.o_instr(instr), .o_instr_valid(valid));
	// compare and count
	task chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// run one word alone, bounded wait for its done pulse
	task step(input [11:0] word);
		integer n;
		begin
			seq.prog[fetch] = word;
			@(posedge i_mclk) run <= 1'b1;
			@(posedge i_mclk) run <= 1'b0;
			n = 0;
			do begin
				@(posedge i_mclk);
				#1 n = n + 1;
			end while (done !== 1'b1 && n < 4);
			if (done !== 1'b1) begin
				miscompares = miscompares + 1;
				tally_and_finish;
			end
		end
	endtask
	// store a byte into a register through the accumulator
	task put(input [6:0] adr, input [7:0] val);
		begin
			step({4'hf, val});
			step({5'h19, adr});
		end
	endtask
	// ================================
	// scenarios
	task t_arith;
		reg [31:0] r;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				r = ARI[i*32 +: 32];
				put(7'h10, r[27:20]);
				step({4'hf, r[19:12]});
				step({r[31:28], 8'h10});
				chk("sum", w, r[11:4]);
				chk("result", res, r[11:4]);
				chk("sum flags", st[2:0], r[3:0]);
			end
		end
	endtask
	task t_regops;
		reg [19:0] r;
		begin
			for (i = 0; i < 9; i = i + 1) begin
				r = REG[i*20 +: 20];
				put(7'h20, 8'h3c);
				step(12'hf0f);
				step(r[19:8]);
				chk("w kept", w, 8'h0f);
				step(12'hc20);
				chk("reg result", w, r[7:0]);
			end
		end
	endtask
	task t_wops;
		reg [27:0] r;
		begin
			for (i = 0; i < 10; i = i + 1) begin
				r = WOP[i*28 +: 28];
				put(7'h02, {4'h0, r[15:12]});
				step(12'hf96);
				step(r[27:16]);
				chk("w op", w, r[11:4]);
				chk("w flags", st[2:0], r[3:0]);
			end
		end
	endtask
	task t_ind;
		reg [9:0] a;
		begin
			put(7'h03, 8'h21);
			step(12'hf5a);
			step(12'hc80);
			step(12'hc21);
			chk("indirect", w, 8'h5a);
			step(12'hc03);
			chk("select", w, 8'h21);
			put(7'h50, 8'h77);
			step(12'hc50);
			chk("unmapped", w, 8'h00);
			chk("zero", st[2], 1'b1);
			a = fetch;
			step(12'hc01);
			chk("ip read", w, {a[7:0] + 8'h01});
		end
	endtask
	task t_jump;
		reg [9:0] a;
		reg [9:0] t;
		integer hits;
		begin
			a = fetch;
			t = {a[9:8], 8'h40};
			seq.prog[a] = 12'hf40;
			seq.prog[a + 10'd1] = 12'hc81;
			seq.prog[a + 10'd2] = 12'hf77; // offered while the jump runs
			for (i = 0; i < 3; i = i + 1)
				seq.prog[t + i] = 12'hf33;
			hits = 0;
			@(posedge i_mclk) run <= 1'b1;
			for (i = 0; i < 5; i = i + 1) begin
				@(posedge i_mclk);
				#1;
				if (flush === 1'b1) begin
					hits = hits + 1;
					chk("jump target", fetch, t);
				end
				if (w === 8'h77)
					hits = hits + 10;
			end
			@(posedge i_mclk) run <= 1'b0;
			repeat (3) @(posedge i_mclk);
			#1 chk("one flush", hits, 1);
			chk("after jump", w, 8'h33);
		end
	endtask
	// ================================
	// main sequence
	initial begin
		repeat (3) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
		#1 chk("reset fetch", fetch, 10'h000);
		chk("reset w", w, 8'h00);
		chk("reset status", st, 8'h00);
		t_arith;
		t_regops;
		t_wops;
		t_ind;
		t_jump;
		tally_and_finish;
	end
endmodule // ebad_core_tb

// ===== tb/ebad_seq_model.sv
/* program store and sequencer stand-in facing the datapath.
   assumes the bench fills prog and raises i_run while words are due. */
`timescale 1ns/1ps
// ================================
// sequencer model
module ebad_seq_model (
	// clock and reset
	input wire i_mclk,
	input wire i_srst,
	// bench control
	input wire i_run,
	// fetch side
	input wire [9:0] i_fetch_addr,
	output wire [11:0] o_instr,
	output wire o_instr_valid
);
	reg [11:0] prog [0:1023]; // 1024 words of 12 bits
	reg [11:0] junk_reg; // idle pattern, so a stale word never looks valid
	// idle bus changes every cycle
	always @(posedge i_mclk) begin
		junk_reg <= i_srst ? 12'ha5a : ~junk_reg + 12'h001;
	end
	assign o_instr_valid = i_run & ~i_srst;
	// word follows the pointer at once, so a jump needs no flush handling here
	assign o_instr = o_instr_valid ? prog[i_fetch_addr] : junk_reg;
endmodule // ebad_seq_model
